/* File: core/adcsr_regs_top.sv */
// Purpose: Identification, status and mode registers of a three-channel
//          converter, seen from its command decoder.
// Assumes: Command decoder gives one-cycle read/write strobes with an
//          index; event inputs are one-cycle pulses on clk_i.
// Notes:   Ready-pin shaping itself lives outside; mode fields go out.
//
// How it works
// - ID bits 11:8 always read three
// - Bit 15 follows lock and unlock commands
// - Bit 14 sets on resync, clears on read
// - Bit 13 map checksum fault, clear on read
// - Bit 12 input checksum error, clear on read
// - Bit 11 mirrors checksum type, reset zero
// - Bit 10 set by reset, mode-zero clears
// - Bits 9:8 mirror word length, default 01
// - Bit 7 fuse fault, holds while persisting
// - Bit 6 high-side fault, resets one, read-clear
// - Status bits 5:3 read zero
// - Bits 2:0 per-channel new data, reset zero
// - Status at 01h, resets to 0540h
// - Mode at 02h, resets 0510h
// - Mode 13/12 enable checksum checks
// - Mode 4 enables timeout, set after reset
// - Mode 3:2 select ready pin source
// - Mode 1 float, mode 0 pulse format
`include "adcsr_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module adcsr_regs_top #(
  parameter logic [7:0] ID_LOW = 8'hA5 // Arbitrary version byte
) (
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 soft_reset_i,
  input  wire logic                 rd_i,
  input  wire logic                 wr_i,
  input  wire adcsr_pkg::adcsr_addr_t addr_i,
  input  wire adcsr_pkg::adcsr_word_t wdata_i,
  input  wire logic                 null_cmd_i,
  input  wire logic                 lock_cmd_i,
  input  wire logic                 unlock_cmd_i,
  input  wire logic                 resync_i,
  input  wire logic                 map_crc_fault_i,
  input  wire logic                 in_crc_fault_i,
  input  wire logic                 fuse_fault_i,
  input  wire logic                 high_side_fault_i,
  input  wire logic [2:0]           new_sample_i,
  input  wire logic [2:0]           sample_taken_i,
  output logic                      rvalid_o,
  output adcsr_pkg::adcsr_word_t    rdata_o,
  output adcsr_pkg::adcsr_word_t    mode_o
);
  import adcsr_pkg::*;

  // ****************************************
  // Registers and next values
  // ****************************************
  logic        lock_ff;
  logic        resync_flag_ff;
  logic        map_crc_ff;
  logic        in_crc_ff;
  logic        reset_flag_ff;
  logic        fuse_ff;
  logic        high_side_fault_ff;
  logic [2:0]  new_sample_ff;
  adcsr_word_t mode_ff;
  logic        nxt_lock;
  logic        nxt_resync_flag;
  logic        nxt_map_crc;
  logic        nxt_in_crc;
  logic        nxt_reset_flag;
  logic        nxt_fuse;
  logic        nxt_high_side_fault;
  adcsr_word_t nxt_mode;
  logic        nxt_rvalid;
  adcsr_word_t nxt_rdata;

  // ****************************************
  // Decode
  // ****************************************
  logic        status_rd;
  logic        mode_wr;
  logic        map_crc_set;
  logic        in_crc_set;
  adcsr_word_t status_w;
  adcsr_word_t id_w;
  assign status_rd   = null_cmd_i |
                       (rd_i & (addr_i == `ADCSR_ADDR_STATUS));
  assign mode_wr     = wr_i & (addr_i == `ADCSR_ADDR_MODE);
  // Checks are off unless enabled, so stray faults are ignored
  assign map_crc_set = map_crc_fault_i &
                       mode_ff[`ADCSR_B_MAPCRC];
  assign in_crc_set  = in_crc_fault_i &
                       mode_ff[`ADCSR_B_INCRC];

  assign id_w = {`ADCSR_ID_TOP_RST, `ADCSR_CHAN_COUNT, ID_LOW};

  assign status_w = {lock_ff, resync_flag_ff, map_crc_ff, in_crc_ff,
                     mode_ff[`ADCSR_B_CRCTYPE],
                     reset_flag_ff,
                     mode_ff[`ADCSR_B_WLEN_HI:`ADCSR_B_WLEN_LO],
                     fuse_ff, high_side_fault_ff,
                     `ADCSR_RSVD_ZERO,
                     new_sample_ff};
  // Reset value of this word composes to 0540h

  // ****************************************
  // Lock indicator
  // ****************************************
  // Unlock wins if both arrive together
  always_comb begin
    nxt_lock = lock_ff;
    if (unlock_cmd_i) begin
      nxt_lock = 1'b0;
    end else if (lock_cmd_i) begin
      nxt_lock = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lock_ff <= 1'b0;
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  // ****************************************
  // Resync flag
  // ****************************************
  // Set beats clear, so an event in a read cycle survives
  always_comb begin
    nxt_resync_flag = resync_flag_ff;
    if (status_rd) begin
      nxt_resync_flag = 1'b0;
    end
    if (resync_i) begin
      nxt_resync_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      resync_flag_ff <= 1'b0;
    end else begin
      resync_flag_ff <= nxt_resync_flag;
    end
  end

  // ****************************************
  // Checksum fault flags
  // ****************************************
  always_comb begin
    nxt_map_crc = map_crc_ff;
    if (status_rd) begin
      nxt_map_crc = 1'b0;
    end
    if (map_crc_set) begin
      nxt_map_crc = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      map_crc_ff <= 1'b0;
    end else begin
      map_crc_ff <= nxt_map_crc;
    end
  end

  always_comb begin
    nxt_in_crc = in_crc_ff;
    if (status_rd) begin
      nxt_in_crc = 1'b0;
    end
    if (in_crc_set) begin
      nxt_in_crc = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      in_crc_ff <= 1'b0;
    end else begin
      in_crc_ff <= nxt_in_crc;
    end
  end

  // ****************************************
  // Fuse and high-side fault flags
  // ****************************************
  // Level inputs: a read only clears while the fault is gone
  always_comb begin
    nxt_fuse = fuse_ff;
    if (status_rd) begin
      nxt_fuse = 1'b0;
    end
    if (fuse_fault_i) begin
      nxt_fuse = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fuse_ff <= 1'b0;
    end else begin
      fuse_ff <= nxt_fuse;
    end
  end

  always_comb begin
    nxt_high_side_fault = high_side_fault_ff;
    if (status_rd) begin
      nxt_high_side_fault = 1'b0;
    end
    if (high_side_fault_i) begin
      nxt_high_side_fault = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      high_side_fault_ff <= 1'b1;
    end else begin
      high_side_fault_ff <= nxt_high_side_fault;
    end
  end

  // ****************************************
  // Reset indicator
  // ****************************************
  // Reset command re-arms it ahead of any clearing write
  always_comb begin
    nxt_reset_flag = reset_flag_ff;
    if (soft_reset_i) begin
      nxt_reset_flag = 1'b1;
    end else if (mode_wr & ~wdata_i[`ADCSR_B_RESET]) begin
      nxt_reset_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      reset_flag_ff <= 1'b1;
    end else begin
      reset_flag_ff <= nxt_reset_flag;
    end
  end

  // ****************************************
  // Data-ready flags
  // ****************************************
  // Set wins over consumption so no sample is lost
  genvar ch;
  generate
    for (ch = 0; ch < `ADCSR_NUM_CH; ch++) begin : g_ch
      logic nxt_flag;
      always_comb begin
        nxt_flag = new_sample_ff[ch];
        if (sample_taken_i[ch]) begin
          nxt_flag = 1'b0;
        end
        if (new_sample_i[ch]) begin
          nxt_flag = 1'b1;
        end
      end
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          new_sample_ff[ch] <= 1'b0;
        end else begin
          new_sample_ff[ch] <= nxt_flag;
        end
      end
    end
  endgenerate

  // ****************************************
  // Mode word
  // ****************************************
  always_comb begin
    nxt_mode = mode_ff;
    if (soft_reset_i) begin
      nxt_mode = `ADCSR_MODE_RST;
    end else if (mode_wr) begin
      nxt_mode = wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_ff <= `ADCSR_MODE_RST;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  assign mode_o = mode_ff;

  // ****************************************
  // Read port
  // ****************************************
  // Data is the pre-clear snapshot taken in the read cycle
  always_comb begin
    nxt_rvalid = rd_i | null_cmd_i;
    nxt_rdata  = rdata_o;
    if (null_cmd_i) begin
      nxt_rdata = status_w;
    end else if (rd_i) begin
      unique case (addr_i)
        `ADCSR_ADDR_ID:     nxt_rdata = id_w;
        `ADCSR_ADDR_STATUS: nxt_rdata = status_w;
        `ADCSR_ADDR_MODE:   nxt_rdata = mode_ff;
        default:            nxt_rdata = `ADCSR_WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= `ADCSR_WORD_ZERO;
    end else begin
      rvalid_o <= nxt_rvalid;
      rdata_o  <= nxt_rdata;
    end
  end
endmodule

`default_nettype wire

/* File: core/adcsr_regs.svh */
// Purpose: Register offsets, field positions and reset values of the
//          identification, status and mode words.
// Assumes: 16-bit registers addressed by a 6-bit register index.
// Notes:   Definitions only.
`ifndef ADCSR_REGS_SVH
`define ADCSR_REGS_SVH

// ****************************************
// Addresses
// ****************************************
`define ADCSR_ADDR_ID      6'h00
`define ADCSR_ADDR_STATUS  6'h01
`define ADCSR_ADDR_MODE    6'h02

// ****************************************
// Reset values
// ****************************************
`define ADCSR_STATUS_RST   16'h0540
`define ADCSR_MODE_RST     16'h0510
`define ADCSR_CHAN_COUNT   4'h3
`define ADCSR_ID_TOP_RST   4'h9 // Arbitrary value
`define ADCSR_WLEN_RST     2'h1
`define ADCSR_RSVD_ZERO    3'h0
`define ADCSR_WORD_ZERO    16'h0000
`define ADCSR_NUM_CH       3

// ****************************************
// Field positions
// ****************************************
`define ADCSR_B_LOCK       15
`define ADCSR_B_RESYNC     14
`define ADCSR_B_MAPCRC     13
`define ADCSR_B_INCRC      12
`define ADCSR_B_CRCTYPE    11
`define ADCSR_B_RESET      10
`define ADCSR_B_WLEN_HI    9
`define ADCSR_B_WLEN_LO    8
`define ADCSR_B_FUSE       7
`define ADCSR_B_HSFAULT    6
`define ADCSR_B_TIMEOUT    4
`define ADCSR_B_SRC_HI     3
`define ADCSR_B_SRC_LO     2
`define ADCSR_B_FLOAT      1
`define ADCSR_B_PULSE      0

`endif

/* File: core/adcsr_pkg.sv */
// Purpose: Types shared by the status/mode register block.
// Assumes: Constants live in adcsr_regs.svh.
// Notes:   Ready-source encodings.
package adcsr_pkg;
  typedef logic [15:0] adcsr_word_t;
  typedef logic [5:0]  adcsr_addr_t;
  typedef enum logic [1:0] {
    ADCSR_SRC_LAGGING = 2'h0,
    ADCSR_SRC_ANY     = 2'h1,
    ADCSR_SRC_LEAD_A  = 2'h2,
    ADCSR_SRC_LEAD_B  = 2'h3
  } adcsr_src_e;
endpackage

/* File: testbench/adcsr_regs_asserts.sv */
// Purpose: Port checks of the status/mode register block
// Assumes: One clock, async active-high reset
// Notes:   Bound to every instance by module name
`timescale 1ns/10ps
`default_nettype none
module adcsr_regs_asserts (
  input wire logic                   clk_i,
  input wire logic                   reset_i,
  input wire logic                   rd_i,
  input wire logic                   wr_i,
  input wire logic                   null_cmd_i,
  input wire adcsr_pkg::adcsr_addr_t addr_i,
  input wire adcsr_pkg::adcsr_word_t wdata_i,
  input wire logic                   rvalid_o,
  input wire adcsr_pkg::adcsr_word_t rdata_o,
  input wire adcsr_pkg::adcsr_word_t mode_o
);
  import adcsr_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire logic st = null_cmd_i || (rd_i && addr_i == 6'h01);
  property p_rv; rd_i || null_cmd_i |=> rvalid_o; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_id; rd_i && addr_i == 6'h00 |=> rdata_o[11:8] == 4'h3; endproperty
  a_id: assert property (p_id) else $error("channel count");
  property p_ty; st |=> rdata_o[11] == $past(mode_o[11]); endproperty
  a_ty: assert property (p_ty) else $error("crc type");
  property p_wl; st |=> rdata_o[9:8] == $past(mode_o[9:8]); endproperty
  a_wl: assert property (p_wl) else $error("word length");
  property p_mw; wr_i && addr_i == 6'h02 |=> mode_o == $past(wdata_i); endproperty
  a_mw: assert property (p_mw) else $error("mode write");
  property p_ro; wr_i && addr_i != 6'h02 |=> $stable(mode_o); endproperty
  a_ro: assert property (p_ro) else $error("ro write");
  property p_mr; $fell(reset_i) |-> mode_o == 16'h0510; endproperty
  a_mr: assert property (p_mr) else $error("mode reset");
  property p_un; rd_i && !null_cmd_i && addr_i > 6'h02 |=> rdata_o == 16'h0000;
  endproperty
  a_un: assert property (p_un) else $error("unmapped");
  c_st: cover property (st ##1 !st ##1 st);
  c_mw: cover property (wr_i && addr_i == 6'h02);
  c_un: cover property (rd_i && addr_i > 6'h02);
endmodule
bind adcsr_regs_top adcsr_regs_asserts i_chk (.*);
`default_nettype wire

/* File: testbench/adcsr_host.sv */
// Purpose: Host command model facing the register block
// Assumes: Commands taken on rising clk_i
// Notes:   Device events ride in the same command word
`timescale 1ns/10ps
`default_nettype none
module adcsr_host (
  input  wire logic        clk_i,
  input  wire logic        rvalid_i,
  input  wire logic [15:0] rdata_i,
  output var  logic [37:0] cmd_o
);
  initial cmd_o = '0;
  task xfer(logic [37:0] c, output logic [15:0] q);
    @(posedge clk_i);
    #1 cmd_o = c;
    @(posedge clk_i);
    #1 cmd_o = {2'h0, c[35:14], 14'h0000}; // Pulses last one edge only
    q = rvalid_i ? rdata_i : 16'hXXXX;
    if (c[37:36] == 2'h1 && c[35:30] == 6'h00) q = q & 16'h0F00;
  endtask
endmodule
`default_nettype wire

/* File: testbench/adcsr_regs_top_tb.sv */
// Purpose: Self-checking bench of the status/mode register block
// Assumes: Host model drives commands and events
// Notes:   Command word is op, addr, wdata, events
`timescale 1ns/10ps
`default_nettype none
module adcsr_regs_top_tb;
  import adcsr_pkg::*;
  localparam logic [13:0] no_ev = 14'h0000;
  localparam adcsr_word_t z16 = 16'h0000;
  logic clk_i = 1'b0, reset_i = 1'b1, rvalid;
  logic [37:0] c;
  adcsr_word_t rdata, q;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  initial forever #4 clk_i = ~clk_i;
  adcsr_host i_host (.clk_i(clk_i), .rvalid_i(rvalid), .rdata_i(rdata),
    .cmd_o(c));
  adcsr_regs_top i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .rd_i(c[37:36] == 2'h1), .wr_i(c[37:36] == 2'h2),
    .null_cmd_i(c[37:36] == 2'h3), .addr_i(c[35:30]), .wdata_i(c[29:14]),
    .soft_reset_i(c[0]), .lock_cmd_i(c[1]), .unlock_cmd_i(c[2]),
    .resync_i(c[3]), .map_crc_fault_i(c[4]), .in_crc_fault_i(c[5]),
    .fuse_fault_i(c[6]), .high_side_fault_i(c[7]), .new_sample_i(c[10:8]),
    .sample_taken_i(c[13:11]), .rvalid_o(rvalid), .rdata_o(rdata),
    .mode_o());
  task chk(adcsr_word_t s, x);
    checks_done++;
    if (s !== x) $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    n_mismatch += (s !== x);
  endtask
  task rc(logic [1:0] o, logic [5:0] a, logic [15:0] d, x, logic [13:0] e);
    i_host.xfer({o, a, d, e}, q);
    if (o[0]) chk(q, x);
  endtask
  task tally_and_finish();
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_i) if (++cyc == 200) begin
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    #125 reset_i = 1'b0;
    rc(2'h1, 6'h01, z16, 16'h0540, no_ev);
    rc(2'h1, 6'h00, z16, 16'h0300, no_ev);
    for (int i = 0; i < 4; i++) begin
      rc(2'h2, 6'h02, {5'h07, 1'b0, i[1:0], 4'h1, i[1:0], i[1:0]}, z16, no_ev);
      rc(2'h3, 6'h00, z16, {4'h0, 2'h2, i[1:0], 8'h00}, no_ev);
    end
    rc(2'h1, 6'h3F, z16, z16, 14'h07FA);
    rc(2'h1, 6'h01, z16, 16'hFBC7, no_ev);
    rc(2'h3, 6'h00, z16, 16'h8B07, 14'h0008);
    rc(2'h1, 6'h01, z16, 16'hCB07, 14'h3804);
    rc(2'h2, 6'h01, 16'hFFFF, z16, no_ev);
    rc(2'h1, 6'h01, z16, 16'h0B00, no_ev);
    rc(2'h0, 6'h3F, z16, z16, 14'h0001);
    rc(2'h1, 6'h01, z16, 16'h0500, no_ev);
    tally_and_finish();
  end
endmodule
`default_nettype wire
